// ---- rtl/cpe_pkg.sv ----
// Package for the channel program executor: opcodes, table slots, timing.
// Assumes a byte-wide local store and a byte-wide program memory.
package cpe_pkg;
  // Clock and basic instruction time
  localparam int CPE_CLK_MHZ = 125;
  localparam int CPE_BASIC_TIME_NS = 750;
  localparam int CPE_BASIC_CYCLES = (CPE_BASIC_TIME_NS * CPE_CLK_MHZ) / 1000;
  localparam logic [7:0] CPE_BASIC_CNT = CPE_BASIC_CYCLES[7:0];
  // Reserved line table entries
  localparam logic [7:0] CPE_LCT_SAVE = 8'h12;
  localparam logic [7:0] CPE_LCT_SP = 8'hf0;
  localparam logic [7:0] CPE_LCT_QHEAD = 8'hf1;
  localparam logic [7:0] CPE_LCT_QTAIL = 8'hf2;
  localparam logic [7:0] CPE_LCT_IADDR = 8'hf3;
  localparam logic [7:0] CPE_LCT_IRANGE = 8'hf4;
  localparam logic [7:0] CPE_LCT_CADDR = 8'hf5;
  localparam logic [7:0] CPE_LCT_CRANGE = 8'hf6;
  localparam logic [7:0] CPE_QFULL_GAP = 8'h0f;
  localparam logic [7:0] CPE_MSB_WEIGHT = 8'h80;
  localparam logic [15:0] CPE_PC_RESET = 16'h0000;
  localparam logic [2:0] CPE_LINE_ONE = 3'h1;
  // Opcodes
  typedef enum logic [4:0] {
    CPE_OP_NOP = 5'h00, CPE_OP_ADD = 5'h01, CPE_OP_AND = 5'h02,
    CPE_OP_BR = 5'h03, CPE_OP_JUMP = 5'h04, CPE_OP_BSAVE = 5'h05,
    CPE_OP_BRET = 5'h06, CPE_OP_CALL = 5'h07, CPE_OP_CRET = 5'h08,
    CPE_OP_PUSH = 5'h09, CPE_OP_PULL = 5'h0a, CPE_OP_ENQ = 5'h0b,
    CPE_OP_DEQ = 5'h0c, CPE_OP_QFULL = 5'h0d, CPE_OP_RCL = 5'h0e,
    CPE_OP_RCR = 5'h0f, CPE_OP_SHR = 5'h10, CPE_OP_TLU = 5'h11,
    CPE_OP_BTEST = 5'h12, CPE_OP_BTSET = 5'h13, CPE_OP_XBTSET = 5'h14,
    CPE_OP_XINC = 5'h15, CPE_OP_REINIT = 5'h16, CPE_OP_RECEIVE_CHAR_OP = 5'h17,
    CPE_OP_SEND = 5'h18, CPE_OP_IN = 5'h19, CPE_OP_OUT = 5'h1a
  } cpe_op_t;
  // Sequencer states
  typedef enum logic [2:0] {
    CPE_ST_FETCH = 3'b000, CPE_ST_OPND = 3'b001, CPE_ST_EXEC = 3'b010,
    CPE_ST_MEM = 3'b011, CPE_ST_MEM2 = 3'b100, CPE_ST_WAIT = 3'b101
  } cpe_state_t;
endpackage : cpe_pkg

// ---- rtl/cpe_core.sv ----
// Channel program executor core: fetch, decode and execute one channel
// program over a byte program port, a byte local store port and a line bus.
// Assumes memories whose read data follows the address in the same cycle.
// Notes on behaviour
// - Short branch adds signed 8-bit displacement
// - Long jump adds signed 16-bit displacement
// - Table operand indexes 256 line table entries
// - Out transfers select line register 0-7; send and receive use line 1
// - Branch-save stores return in entry 18
// - Dequeue loads accumulator, then bumps head
// - Enqueue stores accumulator, then bumps tail
// - Queue-full test: head minus 15 minus tail
// - Call: decrement, store return, decrement, jump
// - Return: increment, load counter, increment
// - Push stores at pointer, then decrements
// - Pull increments pointer, then loads register
// - Rotate left doubles, carry into bit 0
// - Rotate right halves, carry into bit 7
// - Shift right halves, zero into top bit
// - Lookup reads table plus accumulator; load if positive
// - Bit test ANDs mask into work only
// - Test-and-set tests then ORs mask in
// - Extended address is entry byte joined with base
// - Reinit copies initial address and range
// - Send variant picks parity and CRC; receive variant picks CRC only
// - Basic arithmetic takes 0.75 microseconds
// - Stack and queue pointers are table bytes
`timescale 1ns/1ns
module cpe_core import cpe_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  output logic [15:0] prog_addr_out,
  input wire logic [7:0] prog_data_in,
  output logic [15:0] ls_addr_out,
  output logic ls_we_out,
  output logic [7:0] ls_wdata_out,
  input wire logic [7:0] ls_rdata_in,
  output logic line_valid_out,
  input wire logic line_ready_in,
  output logic [2:0] line_sel_out,
  output logic [7:0] line_data_out,
  output logic line_parity_out,
  output logic line_crc_out,
  input wire logic [7:0] line_reg_one_in,
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic zero_out,
  output logic msb_flag_out
);
  // All state of the core except the reset synchronizer in one record
  typedef struct packed {
    cpe_state_t st;
    logic [4:0] op;
    logic [7:0] b1;       // First operand byte
    logic [7:0] b2;       // Second operand byte
    logic [1:0] nopnd;    // Operand bytes for this opcode
    logic [1:0] opix;
    logic [15:0] pc;
    logic [15:0] ipc;     // Address of the opcode byte
    logic [7:0] acc;
    logic [7:0] base;
    logic [7:0] work;     // Hidden from software
    logic carry;
    logic zero;
    logic msb;
    logic [7:0] tmp;
    logic [2:0] step;
    logic [7:0] cnt;      // Holds each basic instruction to its time
    logic [15:0] la;
    logic lwe;
    logic [7:0] lwd;
    logic [7:0] crc;
    // Two-entry output buffer toward the line adapter
    logic [1:0][12:0] fb;
    logic [1:0] fcount;
  } cpe_state_rec_t;

  cpe_state_rec_t s;
  cpe_state_rec_t next_s;
  logic rst_meta;
  logic rst_sync_n;

  // Reset release through two flops
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Operand byte counts per opcode
  function automatic logic [1:0] opnd_bytes(input logic [4:0] op);
    case (op)
      CPE_OP_NOP, CPE_OP_BRET, CPE_OP_CRET, CPE_OP_ENQ, CPE_OP_DEQ,
      CPE_OP_QFULL, CPE_OP_REINIT: opnd_bytes = 2'd0;
      CPE_OP_JUMP, CPE_OP_CALL, CPE_OP_BTSET, CPE_OP_XBTSET,
      CPE_OP_BTEST: opnd_bytes = 2'd2;
      default: opnd_bytes = 2'd1;
    endcase
  endfunction : opnd_bytes

  // Flags from a result byte
  function automatic logic [1:0] zm(input logic [7:0] v);
    zm = {v == 8'h00, v[7]};
  endfunction : zm

  logic buf_push;
  logic [12:0] buf_word;
  logic buf_pop;

  // Next-state logic
  always_comb begin
    logic [8:0] sum;
    logic [7:0] sel;
    sum = 9'h000;
    sel = 8'h00;
    next_s = s;
    next_s.lwe = 1'b0;
    buf_push = 1'b0;
    buf_word = 13'h0000;
    buf_pop = line_ready_in && (s.fcount != 2'd0);
    // Operand select: b1 bit 0 picks base register for shifts/push
    sel = s.b1[0] ? s.base : s.acc;
    case (s.st)
      CPE_ST_FETCH: begin
        next_s.ipc = s.pc;
        next_s.op = prog_data_in[4:0];
        next_s.nopnd = opnd_bytes(prog_data_in[4:0]);
        next_s.opix = 2'd0;
        next_s.pc = s.pc + 16'h0001;
        next_s.step = 3'd0;
        next_s.cnt = CPE_BASIC_CNT;
        next_s.st = (opnd_bytes(prog_data_in[4:0]) == 2'd0) ?
                    CPE_ST_EXEC : CPE_ST_OPND;
      end
      CPE_ST_OPND: begin
        if (s.opix == 2'd0) begin
          next_s.b1 = prog_data_in;
        end else begin
          next_s.b2 = prog_data_in;
        end
        next_s.opix = s.opix + 2'd1;
        next_s.pc = s.pc + 16'h0001;
        if (s.opix + 2'd1 == s.nopnd) begin
          next_s.st = CPE_ST_EXEC;
        end
      end
      CPE_ST_EXEC: begin
        next_s.st = CPE_ST_WAIT;
        case (s.op)
          CPE_OP_ADD, CPE_OP_AND: begin
            // Table operand read next cycle
            next_s.la = {8'h00, s.b1};
            next_s.st = CPE_ST_MEM;
          end
          CPE_OP_BR: begin
            next_s.pc = s.ipc + {{8{s.b1[7]}}, s.b1};
          end
          CPE_OP_JUMP: begin
            next_s.pc = s.ipc + {s.b1, s.b2};
          end
          CPE_OP_BSAVE: begin
            next_s.la = {8'h00, CPE_LCT_SAVE};
            next_s.lwe = 1'b1;
            next_s.lwd = s.pc[7:0];
            next_s.pc = s.ipc + {{8{s.b1[7]}}, s.b1};
          end
          CPE_OP_SHR: begin
            sel = {1'b0, sel[7:1]};
            next_s.carry = s.b1[0] ? s.base[0] : s.acc[0];
            {next_s.zero, next_s.msb} = zm(sel);
            if (s.b1[0]) next_s.base = sel;
            else next_s.acc = sel;
          end
          CPE_OP_RCL: begin
            next_s.carry = sel[7];
            sel = {sel[6:0], s.carry};
            {next_s.zero, next_s.msb} = zm(sel);
            if (s.b1[0]) next_s.base = sel;
            else next_s.acc = sel;
          end
          CPE_OP_RCR: begin
            next_s.carry = sel[0];
            sel = (sel >> 1) | (s.carry ? CPE_MSB_WEIGHT : 8'h00);
            {next_s.zero, next_s.msb} = zm(sel);
            if (s.b1[0]) next_s.base = sel;
            else next_s.acc = sel;
          end
          CPE_OP_REINIT: begin
            next_s.la = {8'h00, CPE_LCT_IADDR};
            next_s.st = CPE_ST_MEM;
          end
          CPE_OP_RECEIVE_CHAR_OP: begin
            next_s.acc = line_reg_one_in;
            {next_s.zero, next_s.msb} = zm(line_reg_one_in);
            if (s.b1[0]) next_s.crc = s.crc ^ line_reg_one_in;
          end
          CPE_OP_SEND, CPE_OP_OUT: begin
            // Stall here while the buffer is full
            if (s.fcount == 2'd2 && !buf_pop) begin
              next_s.st = CPE_ST_EXEC;
            end else begin
              buf_push = 1'b1;
              // Variant bit 1 parity, bit 0 CRC
              buf_word = (s.op == CPE_OP_SEND) ?
                {CPE_LINE_ONE, s.acc, s.b1[1], s.b1[0]} :
                {s.b1[2:0], s.acc, 1'b0, 1'b0};
              if (s.op == CPE_OP_SEND && s.b1[0]) begin
                next_s.crc = s.crc ^ s.acc;
              end
            end
          end
          default: begin
            // Pointer-based and extended forms use the memory phase
            next_s.st = CPE_ST_MEM;
            case (s.op)
              CPE_OP_CALL, CPE_OP_CRET, CPE_OP_PUSH, CPE_OP_PULL:
                next_s.la = {8'h00, CPE_LCT_SP};
              CPE_OP_ENQ: next_s.la = {8'h00, CPE_LCT_QTAIL};
              CPE_OP_DEQ, CPE_OP_QFULL: next_s.la = {8'h00, CPE_LCT_QHEAD};
              CPE_OP_BRET: next_s.la = {8'h00, CPE_LCT_SAVE};
              CPE_OP_NOP: next_s.st = CPE_ST_WAIT;
              default: next_s.la = {8'h00, s.b1};
            endcase
          end
        endcase
      end
      CPE_ST_MEM: begin
        // ls_rdata_in holds the byte at s.la
        next_s.st = CPE_ST_MEM2;
        next_s.tmp = ls_rdata_in;
        next_s.step = s.step + 3'd1;
        case (s.op)
          CPE_OP_ADD: begin
            sum = {1'b0, s.acc} + {1'b0, ls_rdata_in};
            next_s.acc = sum[7:0];
            next_s.carry = sum[8];
            {next_s.zero, next_s.msb} = zm(sum[7:0]);
            next_s.st = CPE_ST_WAIT;
          end
          CPE_OP_AND: begin
            next_s.acc = s.acc & ls_rdata_in;
            {next_s.zero, next_s.msb} = zm(s.acc & ls_rdata_in);
            next_s.st = CPE_ST_WAIT;
          end
          CPE_OP_BRET: begin
            next_s.pc = {s.ipc[15:8], ls_rdata_in};
            next_s.st = CPE_ST_WAIT;
          end
          CPE_OP_BTEST, CPE_OP_BTSET: begin
            next_s.work = ls_rdata_in & s.b2;
            {next_s.zero, next_s.msb} = zm(ls_rdata_in & s.b2);
            if (s.op == CPE_OP_BTSET) begin
              next_s.lwe = 1'b1;
              next_s.lwd = ls_rdata_in | s.b2;
            end
            next_s.st = CPE_ST_WAIT;
          end
          CPE_OP_QFULL: begin
            if (s.step == 3'd0) begin
              next_s.la = {8'h00, CPE_LCT_QTAIL};
              next_s.st = CPE_ST_MEM;
            end else begin
              // Neither pointer written back
              next_s.work = s.tmp - CPE_QFULL_GAP - ls_rdata_in;
              {next_s.zero, next_s.msb} = zm(next_s.work);
              next_s.st = CPE_ST_WAIT;
            end
          end
          default: begin
            next_s.st = CPE_ST_MEM2;
          end
        endcase
      end
      CPE_ST_MEM2: begin
        // Second memory phase; s.tmp holds pointer or entry
        next_s.st = CPE_ST_WAIT;
        case (s.op)
          CPE_OP_ENQ, CPE_OP_DEQ: begin
            if (s.step == 3'd1) begin
              // Access queue byte, then bump pointer
              next_s.la = {8'h00, s.tmp};
              next_s.lwe = (s.op == CPE_OP_ENQ);
              next_s.lwd = s.acc;
              next_s.step = 3'd2;
              next_s.st = CPE_ST_MEM2;
            end else begin
              if (s.op == CPE_OP_DEQ) next_s.acc = ls_rdata_in;
              next_s.la = {8'h00, (s.op == CPE_OP_ENQ) ?
                           CPE_LCT_QTAIL : CPE_LCT_QHEAD};
              next_s.lwe = 1'b1;
              next_s.lwd = s.tmp + 8'h01;
            end
          end
          CPE_OP_PUSH: begin
            if (s.step == 3'd1) begin
              next_s.la = {8'h00, s.tmp};
              next_s.lwe = 1'b1;
              next_s.lwd = s.b1[0] ? s.base : s.acc;
              next_s.step = 3'd2;
              next_s.st = CPE_ST_MEM2;
            end else begin
              next_s.la = {8'h00, CPE_LCT_SP};
              next_s.lwe = 1'b1;
              next_s.lwd = s.tmp - 8'h01;
            end
          end
          CPE_OP_PULL: begin
            case (s.step)
              3'd1: begin
                next_s.tmp = s.tmp + 8'h01;
                next_s.la = {8'h00, s.tmp + 8'h01};
                next_s.lwe = 1'b1;
                next_s.lwd = s.tmp + 8'h01;
                next_s.la = {8'h00, CPE_LCT_SP};
                next_s.step = 3'd2;
                next_s.st = CPE_ST_MEM2;
              end
              3'd2: begin
                next_s.la = {8'h00, s.tmp};
                next_s.step = 3'd3;
                next_s.st = CPE_ST_MEM2;
              end
              default: begin
                if (s.b1[0]) next_s.base = ls_rdata_in;
                else next_s.acc = ls_rdata_in;
              end
            endcase
          end
          CPE_OP_CALL: begin
            // Return address low byte at SP-1, SP ends at SP-2
            if (s.step == 3'd1) begin
              next_s.la = {8'h00, s.tmp - 8'h01};
              next_s.lwe = 1'b1;
              next_s.lwd = s.pc[7:0];
              next_s.step = 3'd2;
              next_s.st = CPE_ST_MEM2;
            end else begin
              next_s.la = {8'h00, CPE_LCT_SP};
              next_s.lwe = 1'b1;
              next_s.lwd = s.tmp - 8'h02;
              next_s.pc = s.ipc + {s.b1, s.b2};
            end
          end
          CPE_OP_CRET: begin
            // Load from SP+1, SP ends at SP+2
            if (s.step == 3'd1) begin
              next_s.la = {8'h00, s.tmp + 8'h01};
              next_s.step = 3'd2;
              next_s.st = CPE_ST_MEM2;
            end else if (s.step == 3'd2) begin
              next_s.step = 3'd3;
              next_s.st = CPE_ST_MEM2;
            end else begin
              next_s.pc = {s.ipc[15:8], ls_rdata_in};
              next_s.la = {8'h00, CPE_LCT_SP};
              next_s.lwe = 1'b1;
              next_s.lwd = s.tmp + 8'h02;
            end
          end
          CPE_OP_TLU: begin
            if (s.step == 3'd1) begin
              next_s.la = {8'h00, s.tmp + s.acc};
              next_s.step = 3'd2;
              next_s.st = CPE_ST_MEM2;
            end else if (s.step == 3'd2) begin
              next_s.step = 3'd3;
              next_s.st = CPE_ST_MEM2;
            end else begin
              next_s.work = ls_rdata_in;
              next_s.msb = ls_rdata_in[7];
              if (!ls_rdata_in[7]) next_s.acc = ls_rdata_in;
            end
          end
          CPE_OP_XBTSET, CPE_OP_XINC: begin
            if (s.step == 3'd1) begin
              next_s.la = {s.tmp, s.base};
              next_s.step = 3'd2;
              next_s.st = CPE_ST_MEM2;
            end else if (s.step == 3'd2) begin
              next_s.step = 3'd3;
              next_s.st = CPE_ST_MEM2;
            end else begin
              next_s.lwe = 1'b1;
              if (s.op == CPE_OP_XINC) begin
                next_s.lwd = ls_rdata_in + 8'h01;
              end else begin
                next_s.work = ls_rdata_in & s.b2;
                next_s.lwd = ls_rdata_in | s.b2;
              end
              {next_s.zero, next_s.msb} = zm(next_s.lwd);
            end
          end
          CPE_OP_REINIT: begin
            // Initial address then range copied to current
            case (s.step)
              3'd1: begin
                next_s.la = {8'h00, CPE_LCT_CADDR};
                next_s.lwe = 1'b1;
                next_s.lwd = s.tmp;
                next_s.step = 3'd2;
                next_s.st = CPE_ST_MEM2;
              end
              3'd2: begin
                next_s.la = {8'h00, CPE_LCT_IRANGE};
                next_s.step = 3'd3;
                next_s.st = CPE_ST_MEM2;
              end
              3'd3: begin
                next_s.step = 3'd4;
                next_s.st = CPE_ST_MEM2;
              end
              default: begin
                next_s.la = {8'h00, CPE_LCT_CRANGE};
                next_s.lwe = 1'b1;
                next_s.lwd = ls_rdata_in;
              end
            endcase
          end
          default: begin
            next_s.st = CPE_ST_WAIT;
          end
        endcase
      end
      CPE_ST_WAIT: begin
        // Pad each instruction to at least the basic time
        if (s.cnt <= 8'd2) next_s.st = CPE_ST_FETCH;
      end
      default: next_s.st = CPE_ST_FETCH;
    endcase
    if (s.st != CPE_ST_FETCH && s.cnt != 8'h00) next_s.cnt = s.cnt - 8'd1;
    // Output buffer bookkeeping: shift out on pop, append on push
    if (buf_pop) begin
      next_s.fb[0] = s.fb[1];
      next_s.fcount = s.fcount - 2'd1;
    end
    if (buf_push) begin
      next_s.fb[next_s.fcount[0]] = buf_word;
      next_s.fcount = next_s.fcount + 2'd1;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
      s.st <= CPE_ST_FETCH;
      s.pc <= CPE_PC_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Memory addressing follows the fetch phase or the held address
  always_comb begin
    prog_addr_out = s.pc;
    ls_addr_out = s.la;
    ls_we_out = s.lwe;
    ls_wdata_out = s.lwd;
  end

  assign line_valid_out = (s.fcount != 2'd0);
  assign line_sel_out = s.fb[0][12:10];
  assign line_data_out = s.fb[0][9:2];
  assign line_parity_out = s.fb[0][1];
  assign line_crc_out = s.fb[0][0];
  assign acc_out = s.acc;
  assign carry_out = s.carry;
  assign zero_out = s.zero;
  assign msb_flag_out = s.msb;
endmodule : cpe_core

// ---- sim/cpe_core_properties.sv ----
// Checker for the executor core: reset, pacing and line handshake.
// Assumes it is bound to cpe_core and sees only its ports.
`timescale 1ns/1ns
module cpe_core_properties import cpe_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] prog_addr_out,
  input wire logic line_valid_out,
  input wire logic line_ready_in,
  input wire logic [2:0] line_sel_out,
  input wire logic [7:0] line_data_out,
  input wire logic line_parity_out,
  input wire logic line_crc_out,
  input wire logic [7:0] acc_out,
  input wire logic carry_out,
  input wire logic zero_out,
  input wire logic msb_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Cycles since the visible state last moved, saturating
  logic [7:0] gap;
  // Updates land 2 to 7 cycles into an instruction, so allow a margin
  // of six; starts saturated so the first update after reset is legal
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap <= 8'hff;
    end else if ($changed({acc_out, carry_out, zero_out, msb_flag_out})) begin
      gap <= 8'h00;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
  AST_FETCH_ZERO: assert property ($rose(reset_n_in) |->
    (prog_addr_out == CPE_PC_RESET) [*3]) else $error("start address");
  AST_RESET_CLEAR: assert property ($rose(reset_n_in) |-> acc_out == 8'h00
    && !carry_out && !zero_out && !msb_flag_out && !line_valid_out)
    else $error("state not cleared");
  AST_PACE_ACC: assert property ($changed(acc_out) |->
    gap >= CPE_BASIC_CNT - 8'h06) else $error("accumulator too early");
  AST_PACE_FLAGS: assert property (
    $changed({carry_out, zero_out, msb_flag_out}) |->
    gap >= CPE_BASIC_CNT - 8'h06) else $error("indicators too early");
  AST_STALL_VALID: assert property (line_valid_out && !line_ready_in |=>
    line_valid_out) else $error("word lost in stall");
  AST_STALL_DATA: assert property (line_valid_out && !line_ready_in |=>
    $stable(line_data_out) && $stable(line_sel_out)) else $error("data moved");
  AST_STALL_VARIANT: assert property (line_valid_out && !line_ready_in |=>
    $stable({line_parity_out, line_crc_out})) else $error("variant moved");
  AST_POP_READY: assert property ($fell(line_valid_out) |->
    $past(line_ready_in)) else $error("valid dropped unasked");
  cover property (line_valid_out && !line_ready_in [*8]);
  cover property (line_valid_out && line_ready_in);
  cover property ($changed(acc_out));
endmodule : cpe_core_properties

bind cpe_core cpe_core_properties cpe_core_properties_i (.ref_clk_in,
  .reset_n_in, .prog_addr_out, .line_valid_out, .line_ready_in,
  .line_sel_out, .line_data_out, .line_parity_out, .line_crc_out,
  .acc_out, .carry_out, .zero_out, .msb_flag_out);

// ---- sim/cpe_line_model.sv ----
// Line adapter model: takes words after a programmable lag, logs them.
// Assumes the core holds valid and its word until ready is seen.
`timescale 1ns/1ns
module cpe_line_model (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] lag_in,
  input wire logic valid_in,
  input wire logic [2:0] sel_in,
  input wire logic [7:0] data_in,
  input wire logic parity_in,
  input wire logic crc_in,
  output logic ready_out
);
  logic [15:0] wait_cnt; // Cycles the head word has waited
  logic [12:0] cap [0:7]; // Taken words: select, parity, crc, data
  int n; // Count of taken words
  // Ready drops after each take, so every word waits the full lag
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_cnt <= 16'h0000;
      ready_out <= 1'b0;
      n <= 0;
    end else if (ready_out && valid_in) begin
      cap[n[2:0]] <= {sel_in, parity_in, crc_in, data_in};
      n <= n + 1;
      ready_out <= 1'b0;
      wait_cnt <= 16'h0000;
    end else if (valid_in) begin
      wait_cnt <= wait_cnt + 16'h0001;
      ready_out <= (wait_cnt >= lag_in);
    end
  end
endmodule : cpe_line_model

// ---- sim/channel_program_executor_bench.sv ----
// Bench for the executor core: byte memories, line model, scenarios.
// Assumes memories answer in the same cycle; address high byte ignored.
`timescale 1ns/1ns
module channel_program_executor_bench import cpe_pkg::*;;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] prog_data_in;
  logic [7:0] ls_rdata_in;
  logic [7:0] line_reg_one_in = 8'h00;
  logic line_ready_in;
  logic [15:0] prog_addr_out, ls_addr_out;
  logic ls_we_out, line_valid_out, line_parity_out, line_crc_out;
  logic [7:0] ls_wdata_out, line_data_out, acc_out;
  logic [2:0] line_sel_out;
  logic carry_out, zero_out, msb_flag_out;
  logic [7:0] rom [0:255]; // Program bytes
  logic [7:0] ls [0:255]; // Local store, line table at the top
  logic [7:0] wp; // Program write pointer
  logic [15:0] lag = 16'h0002; // Line model stall length
  int n_fail = 0;
  int n_compared = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  // Reads follow the address within the cycle, as the core expects;
  // writes land at the clock edge
  assign prog_data_in = rom[prog_addr_out[7:0]];
  assign ls_rdata_in = ls[ls_addr_out[7:0]];
  always @(posedge ref_clk_in) begin
    if (ls_we_out === 1'b1) ls[ls_addr_out[7:0]] <= ls_wdata_out;
  end
  cpe_core cpe_core_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in),
    .ls_addr_out(ls_addr_out), .ls_we_out(ls_we_out),
    .ls_wdata_out(ls_wdata_out), .ls_rdata_in(ls_rdata_in),
    .line_valid_out(line_valid_out), .line_ready_in(line_ready_in),
    .line_sel_out(line_sel_out), .line_data_out(line_data_out),
    .line_parity_out(line_parity_out), .line_crc_out(line_crc_out),
    .line_reg_one_in(line_reg_one_in), .acc_out(acc_out),
    .carry_out(carry_out), .zero_out(zero_out), .msb_flag_out(msb_flag_out));
  cpe_line_model cpe_line_model_i (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .lag_in(lag), .valid_in(line_valid_out),
    .sel_in(line_sel_out), .data_in(line_data_out),
    .parity_in(line_parity_out), .crc_in(line_crc_out),
    .ready_out(line_ready_in));
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task put(input logic [7:0] b);
    rom[wp] = b;
    wp = wp + 8'h01;
  endtask : put
  task op(input cpe_op_t o);
    put({3'h0, o});
  endtask : op
  // Blank program is all NOPs, so running off the end is harmless
  task clear;
    for (int i = 0; i < 256; i++) begin
      rom[i] = 8'h00;
      ls[i] = 8'h00;
    end
    wp = 8'h00;
  endtask : clear
  // Restart from address zero, wait for the fetch of the stop address
  task run(input logic [7:0] stop);
    int i;
    reset_n_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 30000 && prog_addr_out !== {8'h00, stop}; i++)
      @(posedge ref_clk_in);
    chk(prog_addr_out, {8'h00, stop});
    repeat (40) @(posedge ref_clk_in);
  endtask : run
  // Head wraps from ff; full test leaves both pointers alone
  task t_queue;
    clear;
    ls[CPE_LCT_QHEAD] = 8'hff;
    ls[CPE_LCT_QTAIL] = 8'h50;
    ls[8'hff] = 8'h5a;
    op(CPE_OP_DEQ);
    op(CPE_OP_ENQ);
    op(CPE_OP_QFULL);
    run(8'h03);
    chk(acc_out, 16'h005a);
    chk(ls[CPE_LCT_QHEAD], 16'h0000);
    chk(ls[8'h50], 16'h005a);
    chk(ls[CPE_LCT_QTAIL], 16'h0051);
    chk({zero_out, msb_flag_out}, 16'h0001);
  endtask : t_queue
  // Push, call, return, pull; return lands wherever the jump resolves
  task t_stack;
    clear;
    ls[CPE_LCT_SP] = 8'h80;
    ls[CPE_LCT_QHEAD] = 8'h30;
    ls[8'h30] = 8'ha5;
    ls[8'h31] = 8'h11;
    op(CPE_OP_DEQ);
    op(CPE_OP_PUSH);
    put(8'h00);
    op(CPE_OP_DEQ);
    op(CPE_OP_CALL);
    put(8'h00);
    put(8'h0c);
    op(CPE_OP_PULL);
    put(8'h00);
    wp = 8'h10;
    repeat (7) op(CPE_OP_CRET);
    run(8'h09);
    chk(ls[8'h80], 16'h00a5);
    chk(ls[8'h7e], 16'h0007);
    chk(acc_out, 16'h00a5);
    chk(ls[CPE_LCT_SP], 16'h0080);
  endtask : t_stack
  // 81 -> 02 c1 -> 81 c0 -> 40 c1 -> 20, carry kept out of the top
  task t_shift;
    clear;
    ls[CPE_LCT_QHEAD] = 8'h30;
    ls[8'h30] = 8'h81;
    op(CPE_OP_DEQ);
    op(CPE_OP_RCL);
    put(8'h00);
    op(CPE_OP_RCR);
    put(8'h00);
    op(CPE_OP_RCR);
    put(8'h00);
    op(CPE_OP_SHR);
    put(8'h00);
    run(8'h09);
    chk(acc_out, 16'h0020);
  endtask : t_shift
  // Set ORs the mask in; a later plain test must not write
  task t_bits;
    clear;
    ls[8'h20] = 8'h05;
    op(CPE_OP_BTSET);
    put(8'h20);
    put(8'h0a);
    op(CPE_OP_BTEST);
    put(8'h20);
    put(8'hf1);
    run(8'h06);
    chk(ls[8'h20], 16'h000f);
    chk({acc_out, zero_out}, 16'h0000);
  endtask : t_bits
  // Four sends against a slow adapter fill the buffer, then a receive
  task t_line;
    clear;
    lag <= 16'd300;
    line_reg_one_in <= 8'h77;
    ls[CPE_LCT_QHEAD] = 8'h30;
    ls[8'h30] = 8'h3c;
    op(CPE_OP_DEQ);
    for (int i = 0; i < 4; i++) begin
      op(CPE_OP_SEND);
      put(i[7:0]);
    end
    op(CPE_OP_RECEIVE_CHAR_OP);
    put(8'h00);
    run(8'h0b);
    repeat (800) @(posedge ref_clk_in);
    chk(16'(cpe_line_model_i.n), 16'h0004);
    for (int i = 0; i < 4; i++)
      chk(cpe_line_model_i.cap[i], {CPE_LINE_ONE, i[1], i[0], 8'h3c});
    chk(acc_out, 16'h0077);
  endtask : t_line
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_queue;
    t_stack;
    t_shift;
    t_bits;
    t_line;
    test_done;
  end
  // Watchdog well beyond the expected run
  initial begin
    #700000;
    n_fail++;
    test_done;
  end
endmodule : channel_program_executor_bench
